// ### logic/uefr_pkg.sv
package uefr_pkg;

   // -------------------------------------------------------------------
   // Register byte addresses on the APB word map
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_SCRATCH = 8'h00;     // Scratch, swap to level/mode select
   localparam logic [7:0] ADDR_DIV_LOW = 8'h04;     // Integer divisor low byte
   localparam logic [7:0] ADDR_DIV_HIGH = 8'h08;    // Integer divisor high byte
   localparam logic [7:0] ADDR_DIV_FRAC = 8'h0C;    // Fractional divisor
   localparam logic [7:0] ADDR_DEV_ID = 8'h10;      // Identification, read only
   localparam logic [7:0] ADDR_DEV_REV = 8'h14;     // Revision, read only
   localparam logic [7:0] ADDR_TRIGGER = 8'h18;     // User trigger level, write only
   localparam logic [7:0] ADDR_ESC_COUNT = 8'h1C;   // Escaped FIFO count, read only
   localparam logic [7:0] ADDR_FEATURE = 8'h20;     // Feature control
   localparam logic [7:0] ADDR_LINE_CTRL = 8'h24;   // Line control copy
   localparam logic [7:0] ADDR_ENH_FUNC = 8'h28;    // Enhanced function register
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;  // Sticky events, write one to clear
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;    // Interrupt enables
   localparam logic [7:0] ADDR_MODE_READ = 8'h34;   // Mode select readback

   // -------------------------------------------------------------------
   // Field positions and values
   // -------------------------------------------------------------------
   localparam int FEAT_SWAP_BIT = 6;                // Scratch swap
   localparam int FEAT_TARGET_BIT = 7;              // Trigger target select
   localparam int FEAT_IRDA_INV_BIT = 2;            // IrDA receive inversion
   localparam int FEAT_RESERVED_BIT = 3;            // Kept zero by software
   localparam int ENH_FUNC_ENABLE_BIT = 4;          // Enables fraction access
   localparam int MODE_LSR_IMM_BIT = 6;             // Immediate line status irq
   localparam int MODE_SAMPLE16_BIT = 7;            // 16x sampling
   localparam logic [7:0] LCR_ESCAPE = 8'hBF;       // Escape value of line control
   localparam logic [7:0] DEVICE_ID_VALUE = 8'h5C;  // Arbitrary value
   localparam logic [7:0] DEVICE_REV_VALUE = 8'h03; // Arbitrary value

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] RST_SCRATCH = 8'hFF;
   localparam logic [7:0] RST_MODE = 8'h80;         // 16x, delayed irq, RX count
   localparam logic [7:0] RST_FEATURE = 8'h00;
   localparam logic [7:0] RST_DIV_LOW = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [3:0] RST_IRQ = 4'h0;
   localparam logic [4:0] OVERSAMPLE_8X = 5'd8;
   localparam logic [4:0] OVERSAMPLE_16X = 5'd16;

   // Interrupt status bits
   localparam int IRQ_LSR_ERR = 0;                  // Line status error
   localparam int IRQ_RX_TRIG = 1;                  // RX level reached user trigger
   localparam int IRQ_TX_TRIG = 2;                  // TX level at or below user trigger
   localparam int IRQ_MODE_WR = 3;                  // Mode select written

   // Count mode of the swapped scratch location
   typedef enum logic [1:0] {UEFR_CNT_RX, UEFR_CNT_TX, UEFR_CNT_ALT} uefr_cnt_e;

   // Receive character status from the datapath
   typedef struct packed {
      logic push;       // Character enters the RX FIFO
      logic pop;        // Character reaches the holding register
      logic parity;     // Error tags of that character
      logic framing;
      logic brk;
   } uefr_rxev_s;

   // Derived settings handed to the datapath
   typedef struct packed {
      logic [15:0] div_int;   // Integer divisor
      logic [3:0] div_frac;   // Sixteenths
      logic [5:0] hyst;       // Hysteresis in characters
      logic [4:0] oversample; // 8 or 16
      logic irda_inv;         // Idle-high IrDA input
      logic [7:0] rx_trig;    // User RX trigger
      logic [7:0] tx_trig;    // User TX trigger
   } uefr_cfg_s;

endpackage

// ### logic/uefr_hyst_lut.sv
`timescale 1ns/10ps
`default_nettype none
// Hysteresis code to characters, registered output
module uefr_hyst_lut
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [3:0] i_code,
   output logic [5:0] o_chars
);
   logic [5:0] chars_next;

   // ------------------------------------------------------------------
   // Lookup
   // ------------------------------------------------------------------
   always_comb
   begin
      unique case (i_code)
         4'h0: chars_next = 6'd0;
         4'h1: chars_next = 6'd4;
         4'h2: chars_next = 6'd6;
         4'h3: chars_next = 6'd8;
         4'h4: chars_next = 6'd8;
         4'h5: chars_next = 6'd16;
         4'h6: chars_next = 6'd24;
         4'h7: chars_next = 6'd32;
         4'h8: chars_next = 6'd40;
         4'h9: chars_next = 6'd44;
         4'hA: chars_next = 6'd48;
         4'hB: chars_next = 6'd52;
         4'hC: chars_next = 6'd12;
         4'hD: chars_next = 6'd20;
         4'hE: chars_next = 6'd28;
         4'hF: chars_next = 6'd36;
      endcase
   end

   // Register the result
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_chars <= 6'd0;
      else
         o_chars <= chars_next;
   end
endmodule
`default_nettype wire

// ### logic/uefr_top.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Swap bit picks scratch or level count
// - Alternate mode reads RX first, then alternates
// - Four-bit code selects RTS hysteresis
// - Base hysteresis bits reset to zero
// - Error interrupt at holding register or FIFO
// - Sampling bit selects 8x or 16x
// - Swapped read returns selected level count
// - Swapped write goes to mode select
// - Divisor is high:low plus fraction/16
// - Fraction accessible only with enhanced enable
// - Trigger write targets RX or TX level
// - Escaped count needs line control escape
// - Inversion bit selects IrDA idle level
module uefr_top
   import uefr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [7:0] i_rx_level,
   input wire logic [7:0] i_tx_level,
   input wire uefr_pkg::uefr_rxev_s i_rx_event,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq,
   output uefr_pkg::uefr_cfg_s o_cfg
);
   import uefr_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [7:0] scratch_reg;         // Plain scratch contents
   logic [7:0] mode_reg;            // Enhanced mode select
   logic [7:0] feature_reg;         // Feature control
   logic [7:0] div_low_reg;
   logic [7:0] div_high_reg;
   logic [7:0] div_frac_reg;
   logic [7:0] lcr_reg;             // Line control copy
   logic [7:0] efr_reg;             // Enhanced function register
   logic [7:0] rx_trig_reg;
   logic [7:0] tx_trig_reg;
   logic [3:0] irq_status_reg;
   logic [3:0] irq_mask_reg;
   logic alt_tx_reg;                // Next alternating read gives TX
   logic lsr_pend_reg;              // Line status error event, registered one cycle
   logic [5:0] hyst_chars;
   uefr_cnt_e cnt_mode;

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   wire access = i_psel && i_penable;
   wire wr = access && i_pwrite && i_pstrb[0];
   wire rd = access && !i_pwrite;
   wire swap = feature_reg[FEAT_SWAP_BIT];
   wire enh_en = efr_reg[ENH_FUNC_ENABLE_BIT];
   wire escaped = (lcr_reg == LCR_ESCAPE);
   wire hit_scratch = (i_paddr == ADDR_SCRATCH);
   wire hit_frac = (i_paddr == ADDR_DIV_FRAC);
   wire hit_esc = (i_paddr == ADDR_ESC_COUNT);
   wire [7:0] wbyte = i_pwdata[7:0];
   wire wr_scratch = wr && hit_scratch && !swap;
   wire wr_mode = wr && hit_scratch && swap;
   wire wr_frac = wr && hit_frac && enh_en;
   wire rd_alt = rd && hit_scratch && swap && (cnt_mode == UEFR_CNT_ALT);

   // Count mode: bit 0 low is RX, 01 is TX, 11 alternates
   assign cnt_mode = !mode_reg[0] ? UEFR_CNT_RX :
                     (mode_reg[1] ? UEFR_CNT_ALT : UEFR_CNT_TX);

   // Level count at the swapped scratch location
   wire [7:0] swap_level = (cnt_mode == UEFR_CNT_RX) ? i_rx_level :
                           (cnt_mode == UEFR_CNT_TX) ? i_tx_level :
                           (alt_tx_reg ? i_tx_level : i_rx_level);

   // Escaped count follows the trigger target select
   wire [7:0] esc_count = feature_reg[FEAT_TARGET_BIT] ? i_tx_level : i_rx_level;

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   logic [7:0] rdata;
   logic bad_addr;
   always_comb
   begin
      rdata = 8'h00;
      bad_addr = 1'b0;
      unique case (i_paddr)
         ADDR_SCRATCH: rdata = swap ? swap_level : scratch_reg;
         ADDR_DIV_LOW: rdata = div_low_reg;
         ADDR_DIV_HIGH: rdata = div_high_reg;
         ADDR_DIV_FRAC:
         begin
            rdata = enh_en ? div_frac_reg : 8'h00;
            bad_addr = !enh_en;
         end
         ADDR_DEV_ID: rdata = DEVICE_ID_VALUE;
         ADDR_DEV_REV: rdata = DEVICE_REV_VALUE;
         ADDR_TRIGGER: rdata = 8'h00;                            // Write only
         ADDR_ESC_COUNT:
         begin
            rdata = escaped ? esc_count : 8'h00;
            bad_addr = !escaped;
         end
         ADDR_FEATURE: rdata = feature_reg;
         ADDR_LINE_CTRL: rdata = lcr_reg;
         ADDR_ENH_FUNC: rdata = efr_reg;
         ADDR_IRQ_STATUS: rdata = {4'h0, irq_status_reg};
         ADDR_IRQ_MASK: rdata = {4'h0, irq_mask_reg};
         ADDR_MODE_READ: rdata = mode_reg;
         default: bad_addr = 1'b1;
      endcase
   end

   // ------------------------------------------------------------------
   // Bus answer: ready on every access phase, one cycle
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && bad_addr;
         o_prdata <= (i_psel && !i_penable && !i_pwrite) ? {24'h00_0000, rdata} : 32'h0000_0000;
      end
   end
   // Transfer completes when master sees pready in access phase
   wire done = access && o_pready;
   wire done_wr = wr && o_pready;

   // ------------------------------------------------------------------
   // Scratch and mode registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         scratch_reg <= RST_SCRATCH;
         mode_reg <= RST_MODE;
      end
      else
      begin
         if (wr_scratch && o_pready)
            scratch_reg <= wbyte;
         if (wr_mode && o_pready)
            mode_reg <= wbyte;
      end
   end

   // Alternation pointer
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         alt_tx_reg <= 1'b0;
      else if (wr_mode && o_pready)
         alt_tx_reg <= 1'b0;
      else if (rd_alt && o_pready)
         alt_tx_reg <= !alt_tx_reg;
   end

   // ------------------------------------------------------------------
   // Feature, line control, enhanced function, divisor
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         feature_reg <= RST_FEATURE;
         lcr_reg <= RST_ZERO;
         efr_reg <= RST_ZERO;
         div_low_reg <= RST_DIV_LOW;
         div_high_reg <= RST_DIV_HIGH;
         div_frac_reg <= RST_ZERO;
      end
      else if (done_wr)
      begin
         if (i_paddr == ADDR_FEATURE)
            feature_reg <= wbyte;
         if (i_paddr == ADDR_LINE_CTRL)
            lcr_reg <= wbyte;
         if (i_paddr == ADDR_ENH_FUNC)
            efr_reg <= wbyte;
         if (i_paddr == ADDR_DIV_LOW)
            div_low_reg <= wbyte;
         if (i_paddr == ADDR_DIV_HIGH)
            div_high_reg <= wbyte;
         if (wr_frac)
            div_frac_reg <= wbyte;
      end
   end

   // ------------------------------------------------------------------
   // User trigger levels
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_trig_reg <= RST_ZERO;
         tx_trig_reg <= RST_ZERO;
      end
      else if (done_wr && i_paddr == ADDR_TRIGGER)
      begin
         if (feature_reg[FEAT_TARGET_BIT])
            tx_trig_reg <= wbyte;
         else
            rx_trig_reg <= wbyte;
      end
   end

   // ------------------------------------------------------------------
   // Line status error interrupt timing
   // ------------------------------------------------------------------
   wire rx_err = i_rx_event.parity || i_rx_event.framing || i_rx_event.brk;
   wire lsr_imm = mode_reg[MODE_LSR_IMM_BIT];
   wire lsr_event = lsr_imm ? (i_rx_event.push && rx_err)
                            : (i_rx_event.pop && rx_err);
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         lsr_pend_reg <= 1'b0;
      else
         lsr_pend_reg <= lsr_event;
   end

   // ------------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------------
   wire [3:0] ev;
   assign ev[IRQ_LSR_ERR] = lsr_pend_reg;
   assign ev[IRQ_RX_TRIG] = (rx_trig_reg != 8'h00) && (i_rx_level >= rx_trig_reg);
   assign ev[IRQ_TX_TRIG] = (tx_trig_reg != 8'h00) && (i_tx_level <= tx_trig_reg);
   assign ev[IRQ_MODE_WR] = wr_mode && o_pready;
   wire clr_status = done_wr && i_paddr == ADDR_IRQ_STATUS;
   wire [3:0] status_next = (irq_status_reg & ~(clr_status ? wbyte[3:0] : 4'h0)) | ev;
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         irq_status_reg <= RST_IRQ;
         irq_mask_reg <= RST_IRQ;
         o_irq <= 1'b0;
      end
      else
      begin
         irq_status_reg <= status_next;                           // Set beats clear
         if (done_wr && i_paddr == ADDR_IRQ_MASK)
            irq_mask_reg <= wbyte[3:0];
         o_irq <= |(status_next & irq_mask_reg);
      end
   end

   // ------------------------------------------------------------------
   // Hysteresis and config output
   // ------------------------------------------------------------------
   uefr_hyst_lut u_hyst
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_code({mode_reg[5:4], feature_reg[1:0]}),
      .o_chars(hyst_chars)
   );

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_cfg <= '0;
      else
      begin
         o_cfg.div_int <= {div_high_reg, div_low_reg};
         o_cfg.div_frac <= div_frac_reg[3:0];
         o_cfg.hyst <= hyst_chars;
         o_cfg.oversample <= mode_reg[MODE_SAMPLE16_BIT] ? OVERSAMPLE_16X : OVERSAMPLE_8X;
         o_cfg.irda_inv <= feature_reg[FEAT_IRDA_INV_BIT];
         o_cfg.rx_trig <= rx_trig_reg;
         o_cfg.tx_trig <= tx_trig_reg;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   AST_SWAP_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr_mode && o_pready) |=> (mode_reg == $past(wbyte)) && $stable(scratch_reg))
      else $error("Swapped write missed mode select");
   AST_PLAIN_READ: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_psel && !i_penable && !i_pwrite && hit_scratch && !swap) |=> o_prdata[7:0] == $past(scratch_reg))
      else $error("Scratch read wrong");
   AST_ALT_FIRST_RX: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr_mode && o_pready) |=> !alt_tx_reg)
      else $error("Mode write did not restart alternation");
   AST_ALT_TOGGLE: assert property (@(posedge i_clk) disable iff (i_reset)
      (rd_alt && o_pready && !wr_mode) |=> alt_tx_reg != $past(alt_tx_reg))
      else $error("Alternation did not toggle");
   AST_LEVEL_READ: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_psel && !i_penable && !i_pwrite && hit_scratch && swap) |=> o_prdata[7:0] == $past(swap_level))
      else $error("Level read wrong");
   AST_HYST: assert property (@(posedge i_clk) disable iff (i_reset)
      ({mode_reg[5:4], feature_reg[1:0]} == 4'hB) [*2] |=> o_cfg.hyst == 6'd52)
      else $error("Hysteresis wrong");
   AST_FRAC_LOCK: assert property (@(posedge i_clk) disable iff (i_reset)
      (!enh_en && !(done_wr && i_paddr == ADDR_ENH_FUNC)) |=> $stable(div_frac_reg))
      else $error("Fraction changed while locked");
   AST_DIVISOR: assert property (@(posedge i_clk) disable iff (i_reset)
      1'b1 |=> o_cfg.div_int == $past({div_high_reg, div_low_reg}))
      else $error("Divisor wrong");
   AST_TRIG_TX: assert property (@(posedge i_clk) disable iff (i_reset)
      (done_wr && i_paddr == ADDR_TRIGGER && feature_reg[FEAT_TARGET_BIT]) |=> tx_trig_reg == $past(wbyte))
      else $error("TX trigger not written");
   AST_LSR_DELAY: assert property (@(posedge i_clk) disable iff (i_reset)
      (!lsr_imm && i_rx_event.push && !i_rx_event.pop) |=> !lsr_pend_reg)
      else $error("Delayed mode fired early");
   AST_SAMPLE: assert property (@(posedge i_clk) disable iff (i_reset)
      !mode_reg[MODE_SAMPLE16_BIT] |=> o_cfg.oversample == OVERSAMPLE_8X)
      else $error("Oversample wrong");
   AST_ESC_READ: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_psel && !i_penable && !i_pwrite && hit_esc && !escaped) |=> o_prdata == 32'h0000_0000)
      else $error("Escaped count visible");
   COV_ALT: cover property (@(posedge i_clk) rd_alt && o_pready ##[1:20] rd_alt && o_pready);
   COV_SWAP_WR: cover property (@(posedge i_clk) wr_mode && o_pready);
   COV_IRQ: cover property (@(posedge i_clk) o_irq);
endmodule
`default_nettype wire

// ### verif/uefr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor on the APB register port
module uefr_host_model
(
   input wire logic i_clk,
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [7:0] o_paddr,
   output logic [31:0] o_pwdata,
   output logic [3:0] o_pstrb
);
   import uefr_pkg::*;
   // Idle bus at time zero
   initial
   begin
      o_psel = 1'h0;
      o_penable = 1'h0;
      o_pwrite = 1'h0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
      o_pstrb = 4'h0;
   end
   // One transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic e);
      begin
         @(posedge i_clk);
         o_psel <= 1'h1;
         o_pwrite <= w;
         o_paddr <= a;
         o_pwdata <= {24'h0, d};
         o_pstrb <= w ? 4'hF : 4'h0;
         @(posedge i_clk);
         o_penable <= 1'h1;
         // Wait for the rising edge that samples pready high; the answer is taken there
         do @(posedge i_clk); while (i_pready !== 1'h1);
         q = i_prdata[7:0];
         e = i_pslverr;
         o_psel <= 1'h0;
         o_penable <= 1'h0;
      end
   endtask
   // Feature write with the reserved bit kept clear
   task automatic wr_feature(input logic [7:0] d);
      logic [7:0] q;
      logic e;
      xfer(1'h1, ADDR_FEATURE, d & 8'hF7, q, e);
   endtask
   // Identity read, integer divisor zeroed first
   task automatic read_id(output logic [7:0] id, output logic [7:0] rev);
      logic e;
      xfer(1'h1, ADDR_DIV_LOW, 8'h00, id, e);
      xfer(1'h1, ADDR_DIV_HIGH, 8'h00, id, e);
      xfer(1'h0, ADDR_DEV_ID, 8'h00, id, e);
      xfer(1'h0, ADDR_DEV_REV, 8'h00, rev, e);
   endtask
   // Transmit trigger always before receive trigger
   task automatic set_triggers(input logic [7:0] tx, input logic [7:0] rx);
      logic [7:0] q;
      logic e;
      wr_feature(8'h80);
      xfer(1'h1, ADDR_TRIGGER, tx, q, e);
      wr_feature(8'h00);
      xfer(1'h1, ADDR_TRIGGER, rx, q, e);
   endtask
endmodule
`default_nettype wire

// ### verif/test_uefr_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_uefr_top;
   import uefr_pkg::*;
   logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0] paddr, rx_level, tx_level, q, r;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   uefr_rxev_s rx_event;
   uefr_cfg_s cfg;
   int mismatches, n_checks, cycles;
   logic [5:0] hyst_tab [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
                                  6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
   uefr_top u_uefr_top (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_rx_level(rx_level), .i_tx_level(tx_level),
      .i_rx_event(rx_event), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_cfg(cfg));
   uefr_host_model u_uefr_host_model (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
      .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
   // Clock, 100 ns period
   initial
   begin
      i_clk = 1'h0;
      forever #50 i_clk = ~i_clk;
   end
   // Hang guard
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x)
      begin
         $display("[ERR] %s expected %h seen %h", nm, x, g);
         mismatches++;
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      u_uefr_host_model.xfer(w, a, d, q, e);
   endtask
   task automatic settle();
      repeat (3) @(negedge i_clk);
   endtask
   task automatic pulse(input logic [4:0] ev);
      @(posedge i_clk);
      rx_event <= ev;
      @(posedge i_clk);
      rx_event <= 5'h00;
      settle();
   endtask
   task automatic finish_test();
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      i_reset = 1'h1;
      rx_level = 8'h21;
      tx_level = 8'h0E;
      rx_event = 5'h00;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'h0;
      acc(0, ADDR_SCRATCH, 8'h00);
      chk("scratch", 8'hFF, q);
      chk("hyst", 6'h00, cfg.hyst);
      chk("oversample", OVERSAMPLE_16X, cfg.oversample);
      acc(1, ADDR_SCRATCH, 8'h5A);
      acc(0, ADDR_SCRATCH, 8'h00);
      chk("scratch", 8'h5A, q);
      acc(1, ADDR_IRQ_MASK, 8'h09);
      u_uefr_host_model.wr_feature(8'h48);
      acc(1, ADDR_SCRATCH, 8'h01);
      acc(0, ADDR_MODE_READ, 8'h00);
      chk("mode", 8'h01, q);
      chk("oversample", OVERSAMPLE_8X, cfg.oversample);
      chk("irq", 1'h1, irq);
      acc(0, ADDR_SCRATCH, 8'h00);
      chk("level", tx_level, q);
      acc(1, ADDR_SCRATCH, 8'h02);
      acc(0, ADDR_SCRATCH, 8'h00);
      chk("level", rx_level, q);
      acc(1, ADDR_SCRATCH, 8'h83);
      for (int i = 0; i < 3; i++)
      begin
         acc(0, ADDR_SCRATCH, 8'h00);
         chk("alt", (i == 1) ? tx_level : rx_level, q);
      end
      acc(1, ADDR_SCRATCH, 8'h83);
      acc(0, ADDR_SCRATCH, 8'h00);
      chk("alt", rx_level, q);
      acc(1, ADDR_IRQ_STATUS, 8'h08);
      settle();
      chk("irq", 1'h0, irq);
      for (int i = 0; i < 16; i++)
      begin
         u_uefr_host_model.wr_feature(8'h40 | i[1:0]);
         acc(1, ADDR_SCRATCH, {2'h2, i[3:2], 4'h0});
         settle();
         chk("hyst", hyst_tab[i], cfg.hyst);
      end
      acc(1, ADDR_SCRATCH, 8'hC0);
      acc(1, ADDR_IRQ_STATUS, 8'h0F);
      pulse(5'h14);
      chk("irq", 1'h1, irq);
      acc(1, ADDR_SCRATCH, 8'h80);
      acc(1, ADDR_IRQ_STATUS, 8'h0F);
      pulse(5'h12);
      chk("irq", 1'h0, irq);
      pulse(5'h09);
      chk("irq", 1'h1, irq);
      acc(1, ADDR_DIV_LOW, 8'h34);
      acc(1, ADDR_DIV_HIGH, 8'h12);
      acc(1, ADDR_DIV_FRAC, 8'h07);
      chk("frac_err", 1'h1, e);
      acc(1, ADDR_ENH_FUNC, 8'h10);
      acc(1, ADDR_DIV_FRAC, 8'h07);
      settle();
      chk("div_int", 16'h1234, cfg.div_int);
      chk("div_frac", 4'h7, cfg.div_frac);
      u_uefr_host_model.read_id(q, r);
      chk("id", DEVICE_ID_VALUE, q);
      chk("rev", DEVICE_REV_VALUE, r);
      u_uefr_host_model.set_triggers(8'h05, 8'h09);
      settle();
      chk("tx_trig", 8'h05, cfg.tx_trig);
      chk("rx_trig", 8'h09, cfg.rx_trig);
      acc(0, ADDR_IRQ_STATUS, 8'h00);
      chk("irq_status", 8'h03, q);
      acc(0, ADDR_ESC_COUNT, 8'h00);
      chk("esc_err", 1'h1, e);
      acc(1, ADDR_LINE_CTRL, LCR_ESCAPE);
      acc(0, ADDR_ESC_COUNT, 8'h00);
      chk("esc", rx_level, q);
      u_uefr_host_model.wr_feature(8'h84);
      acc(0, ADDR_ESC_COUNT, 8'h00);
      chk("esc", tx_level, q);
      chk("irda_inv", 1'h1, cfg.irda_inv);
      acc(0, 8'h3C, 8'h00);
      chk("unmapped", 1'h1, e);
      finish_test();
   end
endmodule
`default_nettype wire
